// ---- src/rpcm_pkg.sv ----
// Behaviour
// RL1: external agent pulses reset pin high, then low
// RL2: write to reset trigger starts software reset
// RL3: watchdog reset gated by config word and control
// RL4: power-up or pin reset lasts 2^17 cycles
// RL5: brownout, watchdog, software reset last 2^15 cycles
// RL6: all digital pins pulled high during reset
// RL7: pin high stops clocks; falling edge starts sequence
// RL8: strap sampled in reset picks boot mode
// RL9: power-up reset ignored while brownout reset enabled
// RL10: brownout freezes state, resets when supply returns
// RL11: low analog supply sets flag, optional interrupt
// RL12: idle stops cpu, timers, usart only
// RL13: enabled interrupt ends idle
// RL14: stop bit halts all internal clocks
// RL15: stop left only by pin or power-up reset
// RL16: pins hold their values while stopped
// RL17: power-down register gates peripherals
// RL18: osc power-down bit stops oscillator in external mode
// RL19: divider slows system clock and converter clock
// RL20: config word two picks clock, default low osc
// RL21: programming mode always uses low-frequency oscillator
// RL22: code 111 low osc, 110 high osc
// RL23: external clock used only if detected, else fallback
// RL24: pll codes 101 and 100 need detected clock
// RL25: clock detection only once at startup
// RL26: new reset source restarts count with its length
`default_nettype none
package rpcm_pkg;
    // ==========================================
    // register offsets
    localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
    localparam logic [7:0] ADDR_CLK_DIVIDER   = 8'hc7;
    localparam logic [7:0] ADDR_LV_DETECT     = 8'he7;
    localparam logic [7:0] ADDR_FLASH_CONTROL = 8'hee;
    localparam logic [7:0] ADDR_PERIPH_PDOWN  = 8'hf1;
    localparam logic [7:0] ADDR_RESET_TRIGGER = 8'hf7;
    localparam logic [7:0] ADDR_WATCHDOG      = 8'hff;
    // ==========================================
    // field positions
    localparam int POWER_CONTROL_REG_IDLE_BIT  = 0;
    localparam int POWER_CONTROL_REG_STOP_BIT  = 1;
    localparam int PD_OSC_BIT     = 7;
    localparam int LV_FLAG_BIT    = 7;
    localparam int LV_IE_BIT      = 6;
    localparam int WD_EN_BIT      = 7;
    localparam int WD_RESET_BIT   = 0;
    // ==========================================
    // reset values
    localparam logic [7:0] POWER_CONTROL_REG_RESET = 8'h00;
    localparam logic [7:0] DIV_RESET  = 8'h00;
    localparam logic [7:0] LV_RESET   = 8'h00;
    localparam logic [7:0] FM_RESET   = 8'h00;
    localparam logic [7:0] PD_RESET   = 8'h00;
    localparam logic [7:0] WD_RESET   = 8'h00;
    // ==========================================
    // timing counts
    localparam int LONG_RESET_LOG2  = 17;
    localparam int SHORT_RESET_LOG2 = 15;
    // ==========================================
    // clock selection codes
    localparam logic [2:0] CSEL_EXT_A   = 3'h3;
    localparam logic [2:0] CSEL_EXT_B   = 3'h2;
    localparam logic [2:0] CSEL_OSC_LF  = 3'h7;
    localparam logic [2:0] CSEL_OSC_HF  = 3'h6;
    localparam logic [2:0] CSEL_PLL_LF  = 3'h5;
    localparam logic [2:0] CSEL_PLL_HF  = 3'h4;

    typedef enum logic [2:0] {
        RPCM_CK_OSC_LF = 3'h0,
        RPCM_CK_OSC_HF = 3'h1,
        RPCM_CK_EXT    = 3'h2,
        RPCM_CK_PLL_LF = 3'h3,
        RPCM_CK_PLL_HF = 3'h4
    } rpcm_clk_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rpcm_sfr_req_t;

    typedef struct packed {
        logic cpu_run;
        logic timers_run;
        logic usart_run;
        logic others_run;
    } rpcm_gate_t;
endpackage
`default_nettype wire

// ---- src/rpcm_manager.sv ----
`default_nettype none
module rpcm_manager #(
    parameter int LONG_CYCLES  = 1 << rpcm_pkg::LONG_RESET_LOG2,
    parameter int SHORT_CYCLES = 1 << rpcm_pkg::SHORT_RESET_LOG2,
    parameter int PIN_COUNT    = 16
) (
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    input  wire logic                   clk_en,
    input  wire rpcm_pkg::rpcm_sfr_req_t sfr_req,
    output logic [7:0]                  sfr_rdata,
    input  wire logic                   reset_pin,
    input  wire logic                   power_up_reset,
    input  wire logic                   supply_low,
    input  wire logic                   analog_supply_low,
    input  wire logic                   wd_timeout,
    input  wire logic                   any_irq_active,
    input  wire logic                   boot_mode_strap,
    input  wire logic                   ext_clock_seen,
    input  wire logic                   pll_ref_seen,
    input  wire logic                   hw_config_word_0,
    input  wire logic                   hw_config_word_1,
    input  wire logic [2:0]             hw_config_word_2,
    input  wire logic [PIN_COUNT-1:0]   pin_value,
    output logic                        core_reset,
    output logic                        state_frozen,
    output logic [PIN_COUNT-1:0]        pin_force_high,
    output logic                        pin_hold,
    output logic                        user_run_mode,
    output logic                        serial_program_mode,
    output logic                        osc_run,
    output logic                        osc_high_freq,
    output logic                        pll_run,
    output logic                        crystal_run,
    output rpcm_pkg::rpcm_clk_t         clk_active,
    output rpcm_pkg::rpcm_gate_t        gates,
    output logic [7:0]                  periph_power_down,
    output logic [7:0]                  clk_divider,
    output logic                        lv_irq,
    output logic                        sys_clk_halt
);
    localparam int CW = rpcm_pkg::LONG_RESET_LOG2 + 1;

    typedef enum logic [3:0] {
        RPCM_RUN    = 4'b0001,
        RPCM_HOLD   = 4'b0010,
        RPCM_COUNT  = 4'b0100,
        RPCM_STOP   = 4'b1000
    } rpcm_state_t;

    rpcm_state_t state;
    logic [CW-1:0] count;
    logic [7:0] power_control_reg;
    logic [7:0] lvd;
    logic [7:0] fmc;
    logic [7:0] wdc;
    logic reset_pin_q;
    logic in_reset;
    logic pin_fall;
    logic bor_en;
    logic sw_req;
    logic wd_req;
    logic bor_q;
    logic bor_return;
    logic long_req;
    logic short_req;
    logic lv_flag;
    logic clk_checked;

    // ==========================================
    // reset request decode
    assign pin_fall   = reset_pin_q && !reset_pin;                                // see RL7
    assign bor_en     = hw_config_word_1;
    assign bor_return = bor_en && bor_q && !supply_low;                           // see RL10
    assign sw_req     = sfr_req.wr && sfr_req.addr == rpcm_pkg::ADDR_RESET_TRIGGER; // see RL2
    assign wd_req     = hw_config_word_0 && wdc[rpcm_pkg::WD_EN_BIT] && wd_timeout; // see RL3
    assign long_req   = pin_fall || (power_up_reset && !bor_en);                  // see RL9
    assign short_req  = (bor_return || sw_req || wd_req) && state != RPCM_STOP;   // see RL15
    assign in_reset   = state == RPCM_HOLD || state == RPCM_COUNT;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reset_pin_q <= 1'b0;
            bor_q       <= 1'b0;
        end else if (clk_en) begin
            reset_pin_q <= reset_pin;
            bor_q       <= bor_en && supply_low;
        end
    end

    // ==========================================
    // reset sequencer
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= RPCM_COUNT;
            count <= CW'(LONG_CYCLES);
        end else if (clk_en) begin
            if (reset_pin) begin
                state <= RPCM_HOLD;                                               // see RL7
            end else if (long_req) begin
                state <= RPCM_COUNT;                                              // see RL4
                count <= CW'(LONG_CYCLES);                                        // see RL26
            end else if (short_req) begin
                state <= RPCM_COUNT;                                              // see RL5
                count <= CW'(SHORT_CYCLES);                                       // see RL26
            end else if (!(bor_en && supply_low)) begin                           // see RL10
                unique case (state)
                    RPCM_RUN: begin
                        if (power_control_reg[rpcm_pkg::POWER_CONTROL_REG_STOP_BIT])
                            state <= RPCM_STOP;                                   // see RL14
                    end
                    RPCM_HOLD: state <= RPCM_HOLD;
                    RPCM_COUNT: begin
                        if (count <= CW'(1))
                            state <= RPCM_RUN;
                        count <= count - CW'(1);
                    end
                    RPCM_STOP: state <= RPCM_STOP;                                // see RL15
                endcase
            end
        end
    end

    // ==========================================
    // boot mode and clock choice, caught once per reset
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            serial_program_mode <= 1'b0;
            user_run_mode       <= 1'b0;
            clk_checked         <= 1'b0;
            clk_active          <= rpcm_pkg::RPCM_CK_OSC_LF;
        end else if (clk_en) begin
            if (in_reset) begin
                serial_program_mode <= !boot_mode_strap;                          // see RL8
                user_run_mode       <= 1'b0;
                clk_checked         <= 1'b0;
                clk_active          <= rpcm_pkg::RPCM_CK_OSC_LF;                  // see RL4
            end else if (!clk_checked) begin
                clk_checked   <= 1'b1;                                            // see RL25
                user_run_mode <= !serial_program_mode;
                if (serial_program_mode)
                    clk_active <= rpcm_pkg::RPCM_CK_OSC_LF;                       // see RL21
                else if (hw_config_word_2 == rpcm_pkg::CSEL_OSC_HF)
                    clk_active <= rpcm_pkg::RPCM_CK_OSC_HF;                       // see RL22
                else if ((hw_config_word_2 == rpcm_pkg::CSEL_EXT_A ||
                          hw_config_word_2 == rpcm_pkg::CSEL_EXT_B) && ext_clock_seen)
                    clk_active <= rpcm_pkg::RPCM_CK_EXT;                          // see RL23
                else if (hw_config_word_2 == rpcm_pkg::CSEL_PLL_LF && pll_ref_seen)
                    clk_active <= rpcm_pkg::RPCM_CK_PLL_LF;                       // see RL24
                else if (hw_config_word_2 == rpcm_pkg::CSEL_PLL_HF && pll_ref_seen)
                    clk_active <= rpcm_pkg::RPCM_CK_PLL_HF;                       // see RL24
                else
                    clk_active <= rpcm_pkg::RPCM_CK_OSC_LF;                       // see RL20
            end
        end
    end

    // ==========================================
    // register file
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            power_control_reg              <= rpcm_pkg::POWER_CONTROL_REG_RESET;
            clk_divider       <= rpcm_pkg::DIV_RESET;
            lvd               <= rpcm_pkg::LV_RESET;
            fmc               <= rpcm_pkg::FM_RESET;
            periph_power_down <= rpcm_pkg::PD_RESET;
            wdc               <= rpcm_pkg::WD_RESET;
        end else if (clk_en) begin
            if (in_reset) begin
                power_control_reg              <= rpcm_pkg::POWER_CONTROL_REG_RESET;
                clk_divider       <= rpcm_pkg::DIV_RESET;
                lvd               <= rpcm_pkg::LV_RESET;
                fmc               <= rpcm_pkg::FM_RESET;
                periph_power_down <= rpcm_pkg::PD_RESET;
                wdc               <= rpcm_pkg::WD_RESET;
            end else if (state == RPCM_RUN) begin
                if (power_control_reg[rpcm_pkg::POWER_CONTROL_REG_IDLE_BIT] && any_irq_active)
                    power_control_reg[rpcm_pkg::POWER_CONTROL_REG_IDLE_BIT] <= 1'b0;                        // see RL13
                if (sfr_req.wr) begin
                    unique case (sfr_req.addr)
                        rpcm_pkg::ADDR_POWER_CONTROL: power_control_reg              <= sfr_req.wdata;
                        rpcm_pkg::ADDR_CLK_DIVIDER: begin
                            clk_divider <= sfr_req.wdata;                         // see RL19
                        end
                        rpcm_pkg::ADDR_LV_DETECT:     lvd               <= sfr_req.wdata;
                        rpcm_pkg::ADDR_FLASH_CONTROL: fmc               <= sfr_req.wdata;
                        rpcm_pkg::ADDR_PERIPH_PDOWN: begin
                            periph_power_down <= sfr_req.wdata;                   // see RL17
                        end
                        rpcm_pkg::ADDR_WATCHDOG:      wdc               <= sfr_req.wdata;
                        default: ;
                    endcase
                end
            end
        end
    end

    // low-voltage flag: a new low level wins over a clearing write
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            lv_flag <= 1'b0;
            lv_irq  <= 1'b0;
        end else if (clk_en) begin
            if (analog_supply_low)
                lv_flag <= 1'b1;                                                  // see RL11
            else if (sfr_req.wr && sfr_req.addr == rpcm_pkg::ADDR_LV_DETECT &&
                     !sfr_req.wdata[rpcm_pkg::LV_FLAG_BIT])
                lv_flag <= 1'b0;
            lv_irq <= (analog_supply_low || lv_flag) && lvd[rpcm_pkg::LV_IE_BIT]; // see RL11
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sfr_rdata <= 8'h00;
        end else if (clk_en && sfr_req.rd) begin
            unique case (sfr_req.addr)
                rpcm_pkg::ADDR_POWER_CONTROL: sfr_rdata <= power_control_reg;
                rpcm_pkg::ADDR_CLK_DIVIDER:   sfr_rdata <= clk_divider;
                rpcm_pkg::ADDR_LV_DETECT:     sfr_rdata <= {lv_flag, lvd[6:0]};
                rpcm_pkg::ADDR_FLASH_CONTROL: sfr_rdata <= fmc;
                rpcm_pkg::ADDR_PERIPH_PDOWN:  sfr_rdata <= periph_power_down;
                rpcm_pkg::ADDR_WATCHDOG:      sfr_rdata <= wdc;
                default:                      sfr_rdata <= 8'h00;
            endcase
        end
    end

    // ==========================================
    // pins, clocks and gating outputs
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            core_reset     <= 1'b1;
            state_frozen   <= 1'b0;
            pin_force_high <= '1;
            pin_hold       <= 1'b0;
            osc_run        <= 1'b1;
            osc_high_freq  <= 1'b0;
            pll_run        <= 1'b0;
            crystal_run    <= 1'b0;
            sys_clk_halt   <= 1'b0;
            gates          <= '0;
        end else if (clk_en) begin
            core_reset     <= in_reset || reset_pin;
            state_frozen   <= bor_en && supply_low;                               // see RL10
            pin_force_high <= (in_reset || reset_pin) ? '1 : '0;                  // see RL6
            pin_hold       <= state == RPCM_STOP;                                 // see RL16
            sys_clk_halt   <= state == RPCM_STOP;                                 // see RL14
            // the pin gates the oscillators from its own level, not the sequencer state, registered on the next sys_clk edge
            osc_run        <= !reset_pin && state != RPCM_STOP &&
                              !(clk_active == rpcm_pkg::RPCM_CK_EXT &&
                                periph_power_down[rpcm_pkg::PD_OSC_BIT]);         // see RL18
            osc_high_freq  <= clk_active == rpcm_pkg::RPCM_CK_OSC_HF;
            pll_run        <= !reset_pin && state != RPCM_STOP &&
                              (clk_active == rpcm_pkg::RPCM_CK_PLL_LF ||
                               clk_active == rpcm_pkg::RPCM_CK_PLL_HF);           // see RL7
            crystal_run    <= !reset_pin && state != RPCM_STOP &&
                              clk_active == rpcm_pkg::RPCM_CK_EXT;
            gates.cpu_run    <= state == RPCM_RUN && !power_control_reg[rpcm_pkg::POWER_CONTROL_REG_IDLE_BIT]; // see RL12
            gates.timers_run <= state == RPCM_RUN && !power_control_reg[rpcm_pkg::POWER_CONTROL_REG_IDLE_BIT];
            gates.usart_run  <= state == RPCM_RUN && !power_control_reg[rpcm_pkg::POWER_CONTROL_REG_IDLE_BIT];
            gates.others_run <= state == RPCM_RUN;
        end
    end

    // ==========================================
    // checks
    a_sw_reset_starts: assert property (@(posedge sys_clk) disable iff (rst)   // see RL2
        clk_en && sw_req && !reset_pin && !long_req && state == RPCM_RUN
        |=> state == RPCM_COUNT && count == CW'(SHORT_CYCLES))
        else $error("software reset did not load short count");
    a_long_reset_load: assert property (@(posedge sys_clk) disable iff (rst)   // see RL4
        clk_en && pin_fall |=> count == CW'(LONG_CYCLES))
        else $error("pin release did not load long count");
    a_pins_high_reset: assert property (@(posedge sys_clk) disable iff (rst)   // see RL6
        clk_en && in_reset |=> pin_force_high == '1)
        else $error("pins not forced high in reset");
    a_pin_stops_osc: assert property (@(posedge sys_clk) disable iff (rst)     // see RL7
        clk_en && reset_pin |=> !osc_run && !pll_run && !crystal_run)
        else $error("clock sources run while reset pin high");
    a_strap_mode: assert property (@(posedge sys_clk) disable iff (rst)        // see RL8
        clk_en && in_reset |=> serial_program_mode == !$past(boot_mode_strap))
        else $error("boot strap not sampled");
    a_idle_gates: assert property (@(posedge sys_clk) disable iff (rst)        // see RL12
        clk_en && power_control_reg[rpcm_pkg::POWER_CONTROL_REG_IDLE_BIT] && state == RPCM_RUN
        |=> !gates.cpu_run && gates.others_run)
        else $error("idle gating wrong");
    a_stop_sticks: assert property (@(posedge sys_clk) disable iff (rst)       // see RL15
        clk_en && state == RPCM_STOP && !reset_pin && !long_req |=> state == RPCM_STOP)
        else $error("stop left without pin or power-up reset");
    a_lv_flag_set: assert property (@(posedge sys_clk) disable iff (rst)       // see RL11
        clk_en && analog_supply_low |=> lv_flag)
        else $error("low-voltage flag not set");
    a_spl_osc_lf: assert property (@(posedge sys_clk) disable iff (rst)        // see RL21
        user_run_mode == 1'b0 && clk_checked |-> clk_active == rpcm_pkg::RPCM_CK_OSC_LF)
        else $error("programming mode not on low oscillator");
    c_stop_entered: cover property (@(posedge sys_clk) state == RPCM_STOP);
    c_idle_wake: cover property (@(posedge sys_clk)
        power_control_reg[rpcm_pkg::POWER_CONTROL_REG_IDLE_BIT] ##1 !power_control_reg[rpcm_pkg::POWER_CONTROL_REG_IDLE_BIT]);
    c_ext_clock: cover property (@(posedge sys_clk) clk_active == rpcm_pkg::RPCM_CK_EXT);
endmodule
`default_nettype wire

// ---- test/rpcm_ext_reset_model.sv ----
`default_nettype none
module rpcm_ext_reset_model #(
    parameter int HOLD_CYCLES = 4
) (
    input  wire logic sys_clk,
    input  wire logic req,
    input  wire logic clock_present,
    output logic      reset_pin,
    output logic      ext_clock_seen,
    output logic      pll_ref_seen
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================
    // reset pulse: high for some osc periods, then low
    int cnt = 0;
    always_ff @(posedge sys_clk) begin
        if (req && cnt == 0) begin
            cnt <= HOLD_CYCLES;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
        end
    end
    assign reset_pin = (cnt != 0);
    // ==========================================
    // clock detector: level only, the design must latch it at startup
    assign ext_clock_seen = clock_present;
    assign pll_ref_seen   = clock_present;
endmodule
`default_nettype wire

// ---- test/rpcm_manager_tb_top.sv ----
`default_nettype none
module rpcm_manager_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================
    // signals
    logic                    sys_clk = 1'b0, rst = 1'b1, rst_req = 1'b0, present = 1'b0;
    rpcm_pkg::rpcm_sfr_req_t sfr_req = '0;
    logic                    power_up_reset = 1'b0, supply_low = 1'b0, analog_supply_low = 1'b0;
    logic                    wd_timeout = 1'b0, any_irq_active = 1'b0, boot_mode_strap = 1'b1;
    logic                    hw_config_word_0 = 1'b0, hw_config_word_1 = 1'b0;
    logic [2:0]              hw_config_word_2 = 3'h7;
    logic                    reset_pin, ext_clock_seen, pll_ref_seen, core_reset, state_frozen;
    logic                    pin_hold, user_run_mode, serial_program_mode, osc_run, osc_high_freq;
    logic                    pll_run, crystal_run, lv_irq, sys_clk_halt, clk_en = 1'b1;
    logic [15:0]             pin_force_high;
    rpcm_pkg::rpcm_clk_t     clk_active;
    rpcm_pkg::rpcm_gate_t    gates;
    logic [7:0]              sfr_rdata, periph_power_down, clk_divider, rd;
    int                      n_errors = 0, checked = 0, cycles = 0, n;
    logic [7:0]              ra [7] = '{8'h87, 8'hc7, 8'he7, 8'hee, 8'hf1, 8'hff, 8'h80};
    logic [2:0]              cs [7] = '{3'h7, 3'h6, 3'h2, 3'h5, 3'h4, 3'h3, 3'h3};
    logic                    cp [7] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
    rpcm_pkg::rpcm_clk_t     ck [7] = '{rpcm_pkg::RPCM_CK_OSC_LF, rpcm_pkg::RPCM_CK_OSC_HF,
        rpcm_pkg::RPCM_CK_EXT, rpcm_pkg::RPCM_CK_PLL_LF, rpcm_pkg::RPCM_CK_PLL_HF,
        rpcm_pkg::RPCM_CK_OSC_LF, rpcm_pkg::RPCM_CK_EXT};
    // shortened counts keep every reset scenario to a few dozen cycles
    rpcm_manager #(.LONG_CYCLES(20), .SHORT_CYCLES(8)) u_rpcm_manager (
        .sys_clk, .rst, .clk_en, .sfr_req, .sfr_rdata, .reset_pin, .power_up_reset,
        .supply_low, .analog_supply_low, .wd_timeout, .any_irq_active, .boot_mode_strap,
        .ext_clock_seen, .pll_ref_seen, .hw_config_word_0, .hw_config_word_1, .hw_config_word_2,
        .pin_value(16'h00a5), .core_reset, .state_frozen, .pin_force_high, .pin_hold,
        .user_run_mode, .serial_program_mode, .osc_run, .osc_high_freq, .pll_run, .crystal_run,
        .clk_active, .gates, .periph_power_down, .clk_divider, .lv_irq, .sys_clk_halt);
    rpcm_ext_reset_model u_rpcm_ext_reset_model (.sys_clk, .req(rst_req),
        .clock_present(present), .reset_pin, .ext_clock_seen, .pll_ref_seen);
    initial forever #12.5 sys_clk = ~sys_clk;
    // ==========================================
    // tasks: all start and end on a falling edge
    task automatic test_done();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input bit ok, input string msg);
        checked++;
        if (!ok) begin
            n_errors++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(negedge sys_clk);
    endtask
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        sfr_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        tick(1);
        sfr_req = '0;
        tick(1);
    endtask
    task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
        sfr_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        tick(1);
        sfr_req = '0;
        tick(1);
        d = sfr_rdata;
    endtask
    task automatic count_reset(output int k);
        k = 0;
        repeat (6) if (core_reset !== 1'b1) tick(1);
        while (core_reset !== 1'b0 && k < 300) begin
            tick(1);
            k++;
        end
        tick(2);
    endtask
    task automatic pin_reset(output int k);
        rst_req = 1'b1;
        tick(1);
        rst_req = 1'b0;
        tick(2);
        chk(osc_run === 1'b0 && pll_run === 1'b0, "clocks run under reset pin");
        chk(pin_force_high === 16'hffff, "pins not high in reset");
        repeat (20) if (reset_pin !== 1'b0) tick(1);
        count_reset(k);
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            $display("[ERR] %0t timeout", $time);
            test_done();
        end
    end
    // ==========================================
    // scenarios
    initial begin
        tick(4);
        rst = 1'b0;
        chk(core_reset === 1'b1 && pin_force_high === 16'hffff, "reset state");
        count_reset(n);
        chk(n >= 17 && n <= 23, "long reset length");
        chk(clk_active === rpcm_pkg::RPCM_CK_OSC_LF && user_run_mode === 1'b1, "mode");
        foreach (ra[i]) begin
            sfr_rd(ra[i], rd);
            chk(rd === 8'h00, "register reset value");
        end
        sfr_wr(8'hc7, 8'h05);
        sfr_rd(8'hc7, rd);
        chk(clk_divider === 8'h05 && rd === 8'h05, "divider");
        sfr_wr(8'h87, 8'h01);
        chk(gates === 4'b0001, "idle gates");
        any_irq_active = 1'b1;
        tick(3);
        chk(gates.cpu_run === 1'b1, "idle wake");
        any_irq_active = 1'b0;
        sfr_wr(8'hf7, 8'h01);
        count_reset(n);
        chk(n >= 5 && n <= 11, "software reset length");
        sfr_wr(8'hf7, 8'h01);
        power_up_reset = 1'b1;
        tick(1);
        power_up_reset = 1'b0;
        count_reset(n);
        chk(n >= 17 && n <= 24, "count not restarted");
        hw_config_word_1 = 1'b1;
        supply_low = 1'b1;
        tick(3);
        chk(state_frozen === 1'b1, "brownout freeze");
        supply_low = 1'b0;
        count_reset(n);
        chk(n >= 5 && n <= 11, "brownout reset length");
        power_up_reset = 1'b1;
        tick(1);
        power_up_reset = 1'b0;
        tick(3);
        chk(core_reset === 1'b0, "power-up reset not ignored");
        hw_config_word_1 = 1'b0;
        hw_config_word_0 = 1'b1;
        sfr_wr(8'hff, 8'h80);
        wd_timeout = 1'b1;
        tick(1);
        wd_timeout = 1'b0;
        count_reset(n);
        chk(n >= 5 && n <= 12, "watchdog reset");
        hw_config_word_0 = 1'b0;
        sfr_wr(8'he7, 8'h40);
        analog_supply_low = 1'b1;
        tick(2);
        analog_supply_low = 1'b0;
        sfr_rd(8'he7, rd);
        chk(lv_irq === 1'b1 && rd[7] === 1'b1, "low voltage flag");
        sfr_wr(8'hf1, 8'hff);
        chk(periph_power_down === 8'hff, "power down");
        sfr_wr(8'h87, 8'h02);
        // stop state is entered one edge after the write, its outputs one edge later
        tick(1);
        chk(sys_clk_halt === 1'b1 && pin_hold === 1'b1, "stop entry");
        hw_config_word_1 = 1'b1;
        supply_low = 1'b1;
        tick(2);
        supply_low = 1'b0;
        tick(12);
        chk(sys_clk_halt === 1'b1, "brownout woke stop");
        hw_config_word_1 = 1'b0;
        pin_reset(n);
        chk(sys_clk_halt === 1'b0 && n >= 17 && n <= 23, "pin reset from stop");
        boot_mode_strap = 1'b0;
        hw_config_word_2 = 3'h6;
        pin_reset(n);
        chk(serial_program_mode === 1'b1 && clk_active === ck[0], "prog mode");
        boot_mode_strap = 1'b1;
        foreach (cs[i]) begin
            hw_config_word_2 = cs[i];
            present = cp[i];
            pin_reset(n);
            chk(clk_active === ck[i], "clock select");
        end
        present = 1'b0;
        tick(3);
        chk(clk_active === rpcm_pkg::RPCM_CK_EXT, "clock rechecked");
        sfr_wr(8'hf1, 8'h80);
        chk(osc_run === 1'b0, "osc power down");
        clk_en = 1'b0;
        sfr_wr(8'hc7, 8'h09);
        clk_en = 1'b1;
        tick(1);
        chk(clk_divider === 8'h00 && osc_run === 1'b0, "clock enable did not freeze");
        test_done();
    end
endmodule
`default_nettype wire
